//--- rtl/fbd_decoder.sv
`timescale 1ns/1ps
// What this block does
// RULE_01 - Each instruction is one 14-bit word
// RULE_02 - Classify into byte, bit, literal/control groups
// RULE_03 - Destination bit: 0 accumulator, 1 file register
// RULE_04 - File address spans 0x00 to 0x7F
// RULE_05 - Bit index affects one bit only
// RULE_06 - Literal is eight or eleven bits
// RULE_07 - Don't-care opcode bits never change decoding
// RULE_08 - Skip or branch takes two cycles, second NOP
// RULE_09 - Instruction cycle is four oscillator periods
// RULE_10 - Software never uses reserved opcodes
// RULE_11 - Self-modified I/O reads the pin value
// RULE_12 - Two top bits split the instruction classes
// RULE_13 - Branch flushes prefetched word, inserts NOP
module fbd_decoder
  import fbd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [FBD_WORD_W-1:0] i_fetch_word,
  input wire logic i_skip_cond,
  input wire logic i_freg_is_io,
  output logic o_fetch_strobe,
  output logic o_exec_strobe,
  output logic [1:0] o_phase,
  output logic o_flush,
  output logic [1:0] o_group,
  output logic [4:0] o_op,
  output logic [2:0] o_ctrl,
  output logic o_reserved,
  output logic [FBD_FREG_W-1:0] o_freg_addr,
  output logic o_dest_freg,
  output logic o_dest_acc,
  output logic [FBD_BIT_W-1:0] o_bit_index,
  output logic [7:0] o_bit_mask,
  output logic [FBD_LIT8_W-1:0] o_lit8,
  output logic [FBD_LIT11_W-1:0] o_lit11,
  output logic o_lit_is_11,
  output logic o_pc_change,
  output logic o_is_skip,
  output logic o_src_from_pins,
  output logic o_two_cycle
);
  logic [1:0] phase;
  logic cycle_end;
  logic [FBD_WORD_W-1:0] ir_reg;
  logic [FBD_WORD_W-1:0] ir_next;
  logic flush_reg;
  logic flush_next;
  logic second_reg;
  logic second_next;
  fbd_op_t op_reg;
  fbd_op_t op_next;
  fbd_ctrl_t ctrl_reg;
  fbd_ctrl_t ctrl_next;
  fbd_group_t grp_reg;
  fbd_group_t grp_next;
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic dest_freg_reg;
  logic dest_freg_next;
  logic dest_acc_reg;
  logic dest_acc_next;
  logic pc_chg;
  logic skip_op;
  logic writes_self;

  fbd_qclock u_qclock (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .o_phase(phase),
    .o_cycle_end(cycle_end)
  );

  function automatic fbd_op_t decode_op(input logic [FBD_WORD_W-1:0] w);
    fbd_op_t r;
    r = FBD_OP_CTRL;
    unique case (w[13:12]) // RULE_12
      FBD_CLS_BYTE: begin
        unique case (w[11:8])
          4'h0: r = w[7] ? FBD_OP_MOVWF : ((w[6:0] & 7'h1f) == 7'h0 ? FBD_OP_NOP : FBD_OP_CTRL);
          4'h1: r = w[7] ? FBD_OP_CLRF : FBD_OP_CLRW;
          4'h2: r = FBD_OP_SUBWF;
          4'h3: r = FBD_OP_DECF;
          4'h4: r = FBD_OP_IORWF;
          4'h5: r = FBD_OP_ANDWF;
          4'h6: r = FBD_OP_XORWF;
          4'h7: r = FBD_OP_ADDWF;
          4'h8: r = FBD_OP_MOVF;
          4'h9: r = FBD_OP_COMF;
          4'ha: r = FBD_OP_INCF;
          4'hb: r = FBD_OP_DECFSZ;
          4'hc: r = FBD_OP_RRF;
          4'hd: r = FBD_OP_RLF;
          4'he: r = FBD_OP_SWAPF;
          4'hf: r = FBD_OP_INCFSZ;
        endcase
      end
      FBD_CLS_BIT: begin
        unique case (w[11:10])
          2'h0: r = FBD_OP_BCF;
          2'h1: r = FBD_OP_BSF;
          2'h2: r = FBD_OP_BTFSC;
          2'h3: r = FBD_OP_BTFSS;
        endcase
      end
      FBD_CLS_JUMP: r = w[11] ? FBD_OP_GOTO : FBD_OP_CALL;
      FBD_CLS_LIT: begin
        // Bits 9:8 of move/return and bit 8 of add/sub are ignored
        casez (w[11:8]) // RULE_07
          4'b00??: r = FBD_OP_MOVLW;
          4'b01??: r = FBD_OP_RETLW;
          4'b1000: r = FBD_OP_IORLW;
          4'b1001: r = FBD_OP_ANDLW;
          4'b1010: r = FBD_OP_XORLW;
          4'b1011: r = FBD_OP_CTRL;
          4'b110?: r = FBD_OP_SUBLW;
          4'b111?: r = FBD_OP_ADDLW;
          default: r = FBD_OP_CTRL;
        endcase
      end
    endcase
    return r;
  endfunction

  function automatic fbd_ctrl_t decode_ctrl(input logic [FBD_WORD_W-1:0] w);
    fbd_ctrl_t c;
    c = FBD_CT_RESERVED; // RULE_10
    if (w == 14'h0008) begin
      c = FBD_CT_RETURN;
    end else if (w == 14'h0009) begin
      c = FBD_CT_RETFIE;
    end else if (w == 14'h0063) begin
      c = FBD_CT_SLEEP;
    end else if (w == 14'h0064) begin
      c = FBD_CT_CLRWDT;
    end
    return c;
  endfunction

  // Flow control and operand source follow the word now in the register
  always_comb begin
    pc_chg = (op_reg == FBD_OP_CALL) || (op_reg == FBD_OP_GOTO) || (op_reg == FBD_OP_RETLW)
      || (op_reg == FBD_OP_CTRL
      && (ctrl_reg == FBD_CT_RETURN || ctrl_reg == FBD_CT_RETFIE));
    skip_op = (op_reg == FBD_OP_DECFSZ) || (op_reg == FBD_OP_INCFSZ)
      || (op_reg == FBD_OP_BTFSC) || (op_reg == FBD_OP_BTFSS);
    writes_self = (grp_reg == FBD_GRP_BIT && !ir_reg[11])
      || (grp_reg == FBD_GRP_BYTE && ir_reg[7]
      && op_reg != FBD_OP_MOVWF && op_reg != FBD_OP_CLRF);
  end

  // Instruction register loads once per cycle; a flush substitutes a NOP
  always_comb begin
    ir_next = ir_reg;
    flush_next = flush_reg;
    second_next = second_reg;
    if (cycle_end) begin
      flush_next = !flush_reg && (pc_chg || (skip_op && i_skip_cond)); // RULE_08
      second_next = flush_next;
      ir_next = flush_next ? FBD_NOP_WORD : i_fetch_word; // RULE_13
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ir_reg <= FBD_NOP_WORD;
      flush_reg <= 1'b0;
      second_reg <= 1'b0;
    end else begin
      ir_reg <= ir_next;
      flush_reg <= flush_next;
      second_reg <= second_next;
    end
  end

  // Decoding works on the word about to enter the instruction register, so
  // the op, control, group, mask and destination fields leave the block from flip-flops
  always_comb begin
    op_next = decode_op(ir_next); // RULE_01
    ctrl_next = decode_ctrl(ir_next);
    unique case (ir_next[13:12]) // RULE_02
      FBD_CLS_BYTE: grp_next = (op_next == FBD_OP_CTRL) ? FBD_GRP_LITCTL : FBD_GRP_BYTE;
      FBD_CLS_BIT: grp_next = FBD_GRP_BIT;
      default: grp_next = FBD_GRP_LITCTL;
    endcase
    mask_next = 8'h01 << ir_next[9:7]; // RULE_05
    dest_freg_next = (grp_next == FBD_GRP_BYTE) && ir_next[7]; // RULE_03
    dest_acc_next = (grp_next == FBD_GRP_BYTE) && !ir_next[7] // RULE_03
      && op_next != FBD_OP_NOP;
  end

  // Reset values are the decode of the no-operation word
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      op_reg <= FBD_OP_NOP;
      ctrl_reg <= FBD_CT_RESERVED;
      grp_reg <= FBD_GRP_BYTE;
      mask_reg <= 8'h01;
      dest_freg_reg <= 1'b0;
      dest_acc_reg <= 1'b0;
    end else begin
      op_reg <= op_next;
      ctrl_reg <= ctrl_next;
      grp_reg <= grp_next;
      mask_reg <= mask_next;
      dest_freg_reg <= dest_freg_next;
      dest_acc_reg <= dest_acc_next;
    end
  end

  assign o_phase = phase;
  assign o_fetch_strobe = cycle_end;
  assign o_exec_strobe = cycle_end && !second_reg;
  assign o_flush = cycle_end && !flush_reg && (pc_chg || (skip_op && i_skip_cond));
  assign o_group = grp_reg;
  assign o_op = op_reg;
  assign o_ctrl = ctrl_reg;
  assign o_reserved = (op_reg == FBD_OP_CTRL) && (ctrl_reg == FBD_CT_RESERVED);
  assign o_freg_addr = ir_reg[6:0]; // RULE_04
  assign o_dest_freg = dest_freg_reg; // RULE_03
  assign o_dest_acc = dest_acc_reg; // RULE_03
  assign o_bit_index = ir_reg[9:7]; // RULE_05
  assign o_bit_mask = mask_reg; // RULE_05
  assign o_lit8 = ir_reg[7:0]; // RULE_06
  assign o_lit11 = ir_reg[10:0]; // RULE_06
  assign o_lit_is_11 = (op_reg == FBD_OP_CALL) || (op_reg == FBD_OP_GOTO); // RULE_06
  assign o_pc_change = pc_chg;
  assign o_is_skip = skip_op;
  assign o_src_from_pins = writes_self && i_freg_is_io; // RULE_11
  assign o_two_cycle = second_reg;
endmodule

//--- rtl/fbd_pkg.sv
package fbd_pkg;
  localparam int FBD_WORD_W = 14;
  localparam int FBD_FREG_W = 7;
  localparam int FBD_BIT_W = 3;
  localparam int FBD_LIT8_W = 8;
  localparam int FBD_LIT11_W = 11;
  localparam int FBD_QPHASES = 4;
  localparam logic [1:0] FBD_Q_RESET = 2'h0;
  localparam logic [1:0] FBD_Q_LAST = 2'h3;
  localparam logic [13:0] FBD_NOP_WORD = 14'h0000;
  localparam logic [7:0] FBD_FREG_MAX = 8'h7f;
  // Class codes from the two top opcode bits
  localparam logic [1:0] FBD_CLS_BYTE = 2'h0;
  localparam logic [1:0] FBD_CLS_BIT = 2'h1;
  localparam logic [1:0] FBD_CLS_JUMP = 2'h2;
  localparam logic [1:0] FBD_CLS_LIT = 2'h3;

  typedef enum logic [1:0] {
    FBD_GRP_BYTE,
    FBD_GRP_BIT,
    FBD_GRP_LITCTL
  } fbd_group_t;

  typedef enum logic [4:0] {
    FBD_OP_NOP, FBD_OP_MOVWF, FBD_OP_CLRW, FBD_OP_CLRF, FBD_OP_SUBWF, FBD_OP_DECF,
    FBD_OP_IORWF, FBD_OP_ANDWF, FBD_OP_XORWF, FBD_OP_ADDWF, FBD_OP_MOVF, FBD_OP_COMF,
    FBD_OP_INCF, FBD_OP_DECFSZ, FBD_OP_RRF, FBD_OP_RLF, FBD_OP_SWAPF, FBD_OP_INCFSZ,
    FBD_OP_BCF, FBD_OP_BSF, FBD_OP_BTFSC, FBD_OP_BTFSS,
    FBD_OP_CALL, FBD_OP_GOTO, FBD_OP_MOVLW, FBD_OP_RETLW, FBD_OP_IORLW, FBD_OP_ANDLW,
    FBD_OP_XORLW, FBD_OP_SUBLW, FBD_OP_ADDLW,
    FBD_OP_CTRL
  } fbd_op_t;

  typedef enum logic [2:0] {
    FBD_CT_RETURN, FBD_CT_RETFIE, FBD_CT_SLEEP, FBD_CT_CLRWDT, FBD_CT_RESERVED
  } fbd_ctrl_t;
endpackage

//--- rtl/fbd_qclock.sv
`timescale 1ns/1ps
module fbd_qclock
  import fbd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  output logic [1:0] o_phase,
  output logic o_cycle_end
);
  logic [1:0] phase_reg;
  logic [1:0] phase_next;

  // Four oscillator periods per instruction cycle
  always_comb begin
    phase_next = (phase_reg == FBD_Q_LAST) ? FBD_Q_RESET : phase_reg + 2'h1; // RULE_09
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      phase_reg <= FBD_Q_RESET;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign o_phase = phase_reg;
  assign o_cycle_end = (phase_reg == FBD_Q_LAST);
endmodule

//--- verification/fbd_asserts.sv
`timescale 1ns/1ps
module fbd_asserts
  import fbd_pkg::*;
(
  input logic i_clk,
  input logic i_rst,
  input logic o_fetch_strobe,
  input logic o_exec_strobe,
  input logic [1:0] o_phase,
  input logic o_flush,
  input logic [1:0] o_group,
  input logic [4:0] o_op,
  input logic o_dest_freg,
  input logic o_dest_acc,
  input logic [2:0] o_bit_index,
  input logic [7:0] o_bit_mask,
  input logic o_two_cycle
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_phase_wrap: assert property (o_phase == 2'h3 |=> o_phase == 2'h0)
    else $error("phase wrap");
  a_phase_step: assert property (o_phase != 2'h3 |=> o_phase == $past(o_phase) + 2'h1)
    else $error("phase step");
  a_flush_nop: assert property (o_flush |=> o_two_cycle [*4])
    else $error("nop cycle");
  a_nop_quiet: assert property (o_two_cycle |-> !o_flush && !o_exec_strobe)
    else $error("nop active");
  a_dest_excl: assert property (o_dest_freg |-> !o_dest_acc && o_group == 2'h0)
    else $error("dest");
  a_mask_sel: assert property (o_group == 2'h1 |-> $onehot(o_bit_mask) && o_bit_mask[o_bit_index])
    else $error("mask");
  a_group_three: assert property (o_group != 2'h3)
    else $error("group");
  a_op_stands: assert property (!o_fetch_strobe |=> $stable(o_op))
    else $error("op moved");
  c_flush: cover property (o_flush);
  c_bit: cover property (o_group == 2'h1);
  c_acc: cover property (o_dest_acc);
endmodule
bind fbd_decoder fbd_asserts i_fbd_asserts (.*);

//--- verification/fbd_pmem.sv
`timescale 1ns/1ps
module fbd_pmem
  import fbd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_fetch_strobe,
  output logic [FBD_WORD_W-1:0] o_word
);
  logic [FBD_WORD_W-1:0] mem [16];
  logic [3:0] pc_reg;
  // Program holds assigned encodings only, never a reserved word
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = FBD_NOP_WORD;
    end
    mem[0] = 14'h07a5;
    mem[1] = 14'h0725;
    mem[2] = 14'h077f;
    mem[3] = 14'h08a5;
    mem[4] = 14'h1bff;
    mem[5] = 14'h0725;
    mem[6] = 14'h3055;
    mem[7] = 14'h3355;
    mem[8] = 14'h2abc;
    mem[9] = 14'h3055;
    mem[10] = 14'h0008;
    mem[11] = 14'h0725;
    mem[12] = 14'h1c25;
    mem[13] = 14'h3f05;
  end
  // Junk on the bus off the fetch edge
  assign o_word = i_fetch_strobe ? mem[pc_reg] : ~mem[pc_reg];
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pc_reg <= 4'h0;
    end else if (i_fetch_strobe) begin
      pc_reg <= pc_reg + 4'h1;
    end
  end
endmodule

//--- verification/fourteen_bit_instruction_decoder_tb_top.sv
`timescale 1ns/1ps
module fourteen_bit_instruction_decoder_tb_top;
  import fbd_pkg::*;
  logic i_clk, i_rst, i_skip_cond, i_freg_is_io, o_fetch_strobe, o_exec_strobe, o_flush;
  logic o_reserved, o_dest_freg, o_dest_acc, o_lit_is_11, o_pc_change, o_is_skip;
  logic o_src_from_pins, o_two_cycle;
  logic [13:0] i_fetch_word;
  logic [1:0] o_phase, o_group;
  logic [4:0] o_op;
  logic [2:0] o_ctrl, o_bit_index;
  logic [6:0] o_freg_addr;
  logic [7:0] o_bit_mask, o_lit8;
  logic [10:0] o_lit11;
  int err_count, tests_run;
  fbd_decoder i_fbd_decoder (.*);
  fbd_pmem i_fbd_pmem (.i_clk, .i_rst, .i_fetch_strobe(o_fetch_strobe), .o_word(i_fetch_word));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic q3;
    repeat (8) if (o_fetch_strobe !== 1'b1) @(posedge i_clk) #1;
    if (o_fetch_strobe !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t fetch strobe missing", $time);
      complete_run;
    end
  endtask
  task automatic nxt;
    q3;
    @(posedge i_clk) #1;
  endtask
  task automatic t_byte;
    nxt;
    chk({o_op, o_group, o_dest_freg, o_freg_addr}, {FBD_OP_ADDWF, 3'h1, 7'h25});
    nxt;
    chk({o_dest_acc, o_dest_freg}, 2'h2);
    nxt;
    chk(o_freg_addr, 7'h7f);
    nxt;
    chk({o_op, o_src_from_pins}, {FBD_OP_MOVF, 1'b0});
    @(posedge i_clk) i_freg_is_io <= 1'b1;
    #1;
    chk({o_op, o_src_from_pins}, {FBD_OP_MOVF, 1'b1});
  endtask
  task automatic t_bit;
    nxt;
    chk({o_op, o_group, o_bit_index, o_bit_mask}, {FBD_OP_BTFSC, 2'h1, 3'h7, 8'h80});
    @(posedge i_clk) i_skip_cond <= 1'b1;
    q3;
    chk({o_flush, o_exec_strobe}, 2'h3);
    nxt;
    chk({o_two_cycle, o_op}, {1'b1, FBD_OP_NOP});
    @(posedge i_clk) i_skip_cond <= 1'b0;
    q3;
    chk({o_flush, o_exec_strobe}, 2'h0);
  endtask
  task automatic t_lit;
    nxt;
    chk({o_op, o_group, o_lit8}, {FBD_OP_MOVLW, 2'h2, 8'h55});
    nxt;
    chk({o_op, o_lit8}, {FBD_OP_MOVLW, 8'h55});
    nxt;
    chk({o_lit_is_11, o_pc_change, o_lit11}, {2'h3, 11'h2bc});
    q3;
    chk(o_flush, 1'b1);
    nxt;
    chk(o_two_cycle, 1'b1);
  endtask
  task automatic t_ctrl;
    nxt;
    chk({o_op, o_group, o_ctrl, o_pc_change, o_reserved}, {FBD_OP_CTRL, 2'h2, FBD_CT_RETURN, 2'h2});
    q3;
    chk({o_flush, o_exec_strobe}, 2'h3);
    nxt;
    chk({o_two_cycle, o_op, o_reserved}, {1'b1, FBD_OP_NOP, 1'b0});
    nxt;
    chk({o_op, o_is_skip, o_bit_mask}, {FBD_OP_BTFSS, 1'b1, 8'h01});
    q3;
    chk({o_flush, o_exec_strobe, o_pc_change}, 3'h2);
    nxt;
    chk({o_two_cycle, o_op, o_lit8, o_lit_is_11}, {1'b0, FBD_OP_ADDLW, 8'h05, 1'b0});
  endtask
  task automatic complete_run;
    $display("Checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    err_count = 0;
    tests_run = 0;
    i_rst = 1'b1;
    i_skip_cond = 1'b0;
    i_freg_is_io = 1'b0;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    t_byte;
    t_bit;
    t_lit;
    t_ctrl;
    complete_run;
  end
  initial begin
    #3000;
    err_count++;
    complete_run;
  end
endmodule
